/* svr_cfg.svh */
// Timing and level constants for the supervisor block.
`ifndef SVR_CFG_SVH
`define SVR_CFG_SVH
`define SVR_CLK_MHZ 125
`define SVR_RST_TIMEOUT_MS 200
`define SVR_WDOG_TIMEOUT_MS 1600
`define SVR_CS_DELAY_US 28
`define SVR_AUX_FALL_US 14
`define SVR_AUX_RISE_US 32
`define SVR_MS_CYCLES (`SVR_CLK_MHZ * 1000)
`define SVR_RST_CYCLES (`SVR_RST_TIMEOUT_MS * `SVR_MS_CYCLES)
`define SVR_WDOG_CYCLES (`SVR_WDOG_TIMEOUT_MS * `SVR_MS_CYCLES)
`define SVR_CS_CYCLES (`SVR_CS_DELAY_US * `SVR_CLK_MHZ)
`define SVR_AUX_FALL_CYCLES (`SVR_AUX_FALL_US * `SVR_CLK_MHZ)
`define SVR_AUX_RISE_CYCLES (`SVR_AUX_RISE_US * `SVR_CLK_MHZ)
`define SVR_CNT_W 32
`define SVR_ZERO 32'h0000_0000
`define SVR_ONE 32'h0000_0001
`endif

/* svr_pkg.sv */
// Types shared by the supervisor block.
package svr_pkg;
  typedef enum logic [1:0] {SVR_RUN, SVR_HOLD, SVR_STRETCH} svr_rst_state_t;
endpackage

/* svr_sync.sv */
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ns
`default_nettype none
module svr_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* svr_top.sv */
// Supervisor: reset stretch, watchdog, chip-select gate and early warnings.
// Summary of operation
// - Hold reset low while supply is low.
// - High reset is always complement of low reset.
// - Manual reset low stretches reset 200 ms.
// - Filter bouncing manual input; open reads high.
// - Fault low after 1.6 s without kick.
// - Kick edge or reset clears the watchdog.
// - Watchdog stopped while reset, starts on release.
// - Fault stays low until next kick edge or watchdog off.
// - Watchdog off during supply low or floating kick.
// - Looped fault gives periodic 200 ms resets.
// - Chip select passes normally, blocked in reset.
// - Power-down block comes 28 us after reset.
// - Power-up keeps chip select blocked until release.
// - Blocked chip select output forced high.
// - Supply warning precedes reset, hysteresis on release.
// - Aux fail low while monitor below trip.
// - Aux fail delays 14 us fall, 32 us rise.
// - Every reset lasts at least timeout after cause.
// - Supply low during stretch restarts count.
`timescale 1ns/1ns
`default_nettype none
`include "svr_cfg.svh"
module svr_top #(
  parameter int unsigned RST_CYCLES = `SVR_RST_CYCLES,
  parameter int unsigned WDOG_CYCLES = `SVR_WDOG_CYCLES,
  parameter int unsigned CS_CYCLES = `SVR_CS_CYCLES,
  parameter int unsigned AUX_FALL_CYCLES = `SVR_AUX_FALL_CYCLES,
  parameter int unsigned AUX_RISE_CYCLES = `SVR_AUX_RISE_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire logic SUPPLY_WARN_IN,
  input wire logic MANUAL_RESET_IN,
  input wire logic WATCHDOG_KICK_IN,
  input wire logic KICK_FLOAT_IN,
  input wire logic CHIP_SELECT_N_IN,
  input wire logic AUX_MONITOR_IN,
  output logic RESET_N_OUT,
  output logic RESET_OUT,
  output logic WATCHDOG_FAULT_OUT,
  output logic CHIP_SELECT_N_OUT,
  output logic CHIP_SELECT_OE_OUT,
  output logic SUPPLY_WARN_N_OUT,
  output logic AUX_FAIL_OUT
);
  import svr_pkg::*;

  logic supply_low_s, supply_warn_s, manual_s, kick_s, float_s, cs_s, aux_s;
  logic kick_prev_ff;
  logic kick_edge;
  svr_rst_state_t rst_state_ff, nxt_rst_state;
  logic [`SVR_CNT_W-1:0] rst_cnt_ff;
  logic [`SVR_CNT_W-1:0] wd_cnt_ff;
  logic [`SVR_CNT_W-1:0] cs_cnt_ff;
  logic [`SVR_CNT_W-1:0] aux_cnt_ff;
  logic [`SVR_CNT_W-1:0] mr_cnt_ff;
  logic manual_clean_ff;
  logic cs_block_ff;
  logic rst_active;
  logic wd_enable;

  function automatic logic cnt_done(input logic [`SVR_CNT_W-1:0] cnt, input int unsigned lim);
    cnt_done = (cnt >= `SVR_CNT_W'(lim - 1));
  endfunction

  // Every asynchronous input passes two flops before any logic reads it.
  svr_sync #(.RESET_VAL(1'b1)) u_sync_low (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(SUPPLY_LOW_IN),
    .q_out(supply_low_s)
  );
  svr_sync #(.RESET_VAL(1'b0)) u_sync_warn (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(SUPPLY_WARN_IN),
    .q_out(supply_warn_s)
  );
  svr_sync #(.RESET_VAL(1'b1)) u_sync_mr (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(MANUAL_RESET_IN),
    .q_out(manual_s)
  );
  svr_sync #(.RESET_VAL(1'b0)) u_sync_kick (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(WATCHDOG_KICK_IN),
    .q_out(kick_s)
  );
  svr_sync #(.RESET_VAL(1'b0)) u_sync_float (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(KICK_FLOAT_IN),
    .q_out(float_s)
  );
  svr_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(CHIP_SELECT_N_IN),
    .q_out(cs_s)
  );
  svr_sync #(.RESET_VAL(1'b1)) u_sync_aux (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(AUX_MONITOR_IN),
    .q_out(aux_s)
  );

  // A bouncing switch only pulls reset on the first low; the release must hold
  // high for a full millisecond before it counts, so bounce cannot end the pulse.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      manual_clean_ff <= 1'b1;
      mr_cnt_ff <= `SVR_ZERO;
    end else if (!manual_s) begin
      manual_clean_ff <= 1'b0;
      mr_cnt_ff <= `SVR_ZERO;
    end else if (!manual_clean_ff) begin
      if (cnt_done(mr_cnt_ff, `SVR_MS_CYCLES)) begin
        manual_clean_ff <= 1'b1;
      end
      mr_cnt_ff <= mr_cnt_ff + `SVR_ONE;
    end
  end

  assign rst_active = (rst_state_ff != SVR_RUN);

  always_comb begin
    nxt_rst_state = rst_state_ff;
    unique case (rst_state_ff)
      SVR_RUN: begin
        if (supply_low_s || !manual_clean_ff) begin
          nxt_rst_state = SVR_HOLD;
        end
      end
      SVR_HOLD: begin
        if (!supply_low_s && manual_clean_ff) begin
          nxt_rst_state = SVR_STRETCH;
        end
      end
      SVR_STRETCH: begin
        if (supply_low_s || !manual_clean_ff) begin
          nxt_rst_state = SVR_HOLD;
        end else if (cnt_done(rst_cnt_ff, RST_CYCLES)) begin
          nxt_rst_state = SVR_RUN;
        end
      end
    endcase
  end

  // Power-on starts in hold so the first release is stretched as well.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_state_ff <= SVR_HOLD;
    end else begin
      rst_state_ff <= nxt_rst_state;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_cnt_ff <= `SVR_ZERO;
    end else if (rst_state_ff == SVR_STRETCH && nxt_rst_state == SVR_STRETCH) begin
      rst_cnt_ff <= rst_cnt_ff + `SVR_ONE;
    end else begin
      rst_cnt_ff <= `SVR_ZERO;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RESET_N_OUT <= 1'b0;
      RESET_OUT <= 1'b1;
    end else begin
      RESET_N_OUT <= (nxt_rst_state == SVR_RUN);
      RESET_OUT <= (nxt_rst_state != SVR_RUN);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      kick_prev_ff <= 1'b0;
    end else begin
      kick_prev_ff <= kick_s;
    end
  end
  assign kick_edge = kick_s ^ kick_prev_ff;
  assign wd_enable = !rst_active && !supply_low_s && !float_s;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wd_cnt_ff <= `SVR_ZERO;
      WATCHDOG_FAULT_OUT <= 1'b1;
    end else if (!wd_enable || kick_edge) begin
      wd_cnt_ff <= `SVR_ZERO;
      WATCHDOG_FAULT_OUT <= 1'b1;
    end else if (cnt_done(wd_cnt_ff, WDOG_CYCLES)) begin
      WATCHDOG_FAULT_OUT <= 1'b0;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + `SVR_ONE;
    end
  end

  // A supply-low reset keeps the gate open for the delay so a write in flight
  // can finish; any other reset, including power-up, blocks it at once.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cs_block_ff <= 1'b1;
      cs_cnt_ff <= `SVR_ZERO;
    end else if (!rst_active) begin
      cs_block_ff <= 1'b0;
      cs_cnt_ff <= `SVR_ZERO;
    end else if (!cs_block_ff && supply_low_s && manual_clean_ff) begin
      if (cnt_done(cs_cnt_ff, CS_CYCLES)) begin
        cs_block_ff <= 1'b1;
      end
      cs_cnt_ff <= cs_cnt_ff + `SVR_ONE;
    end else begin
      cs_block_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CHIP_SELECT_N_OUT <= 1'b1;
      CHIP_SELECT_OE_OUT <= 1'b1;
    end else begin
      CHIP_SELECT_N_OUT <= cs_block_ff ? 1'b1 : cs_s;
      CHIP_SELECT_OE_OUT <= 1'b1;
    end
  end

  // The warning comparator already applies its hysteresis; the block passes it.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SUPPLY_WARN_N_OUT <= 1'b0;
    end else begin
      SUPPLY_WARN_N_OUT <= !supply_warn_s;
    end
  end

  // The monitor must differ from the output for the full delay before it flips.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      AUX_FAIL_OUT <= 1'b1;
      aux_cnt_ff <= `SVR_ZERO;
    end else if (aux_s == AUX_FAIL_OUT) begin
      aux_cnt_ff <= `SVR_ZERO;
    end else if (cnt_done(aux_cnt_ff, aux_s ? AUX_RISE_CYCLES : AUX_FALL_CYCLES)) begin
      AUX_FAIL_OUT <= aux_s;
      aux_cnt_ff <= `SVR_ZERO;
    end else begin
      aux_cnt_ff <= aux_cnt_ff + `SVR_ONE;
    end
  end

  reset_pair_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    RESET_OUT == !RESET_N_OUT) else $error("Reset outputs not complementary.");
  supply_reset_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    supply_low_s |=> !RESET_N_OUT) else $error("Reset not held in supply low.");
  manual_reset_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !manual_s |=> ##1 !RESET_N_OUT) else $error("Manual reset ignored.");
  stretch_min_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(RESET_N_OUT) |-> rst_state_ff == SVR_RUN && $past(rst_state_ff) == SVR_STRETCH)
    else $error("Reset released without stretch.");
  wd_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    rst_active |=> wd_cnt_ff == `SVR_ZERO && WATCHDOG_FAULT_OUT)
    else $error("Watchdog ran during reset.");
  wd_kick_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    kick_edge |=> WATCHDOG_FAULT_OUT) else $error("Kick did not clear fault.");
  wd_sticky_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !WATCHDOG_FAULT_OUT && wd_enable && !kick_edge |=> !WATCHDOG_FAULT_OUT)
    else $error("Fault dropped without kick.");
  wd_float_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    float_s |=> WATCHDOG_FAULT_OUT) else $error("Fault with floating kick.");
  cs_block_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    cs_block_ff |=> CHIP_SELECT_N_OUT) else $error("Chip select not forced high.");
  cs_pass_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !rst_active && !cs_block_ff |=> CHIP_SELECT_N_OUT == $past(cs_s))
    else $error("Chip select not passed.");

  // Some of the checks below pin the watchdog, stretch and manual-release delays to the counters that carry them, so an
  // off-by-one in those limits shows up at once rather than as a slow drift.
  supply_warn_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> SUPPLY_WARN_N_OUT == !$past(supply_warn_s))
    else $error("Warning output not passed.");

  aux_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    aux_s == AUX_FAIL_OUT |=> $stable(AUX_FAIL_OUT))
    else $error("Aux output moved without cause.");

  aux_follow_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $changed(AUX_FAIL_OUT) |-> AUX_FAIL_OUT == $past(aux_s))
    else $error("Aux output took a wrong level.");

  cs_stay_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    cs_block_ff && rst_active |=> cs_block_ff)
    else $error("Chip select opened during reset.");

  cs_open_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !rst_active |=> !cs_block_ff)
    else $error("Chip select not opened after reset.");

  wd_timeout_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    wd_enable && !kick_edge && wd_cnt_ff == `SVR_CNT_W'(WDOG_CYCLES - 1)
    |=> !WATCHDOG_FAULT_OUT) else $error("Fault missing at timeout.");

  wd_early_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    WATCHDOG_FAULT_OUT && wd_cnt_ff < `SVR_CNT_W'(WDOG_CYCLES - 1)
    |=> WATCHDOG_FAULT_OUT) else $error("Fault before timeout.");

  rst_restart_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    rst_state_ff == SVR_STRETCH && supply_low_s |=> rst_cnt_ff == `SVR_ZERO)
    else $error("Stretch count not restarted.");

  stretch_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    rst_state_ff == SVR_STRETCH && rst_cnt_ff < `SVR_CNT_W'(RST_CYCLES - 1)
    |=> !RESET_N_OUT) else $error("Reset released before timeout.");

  manual_filter_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !manual_clean_ff && mr_cnt_ff < `SVR_CNT_W'(`SVR_MS_CYCLES - 1)
    |=> !manual_clean_ff) else $error("Manual release not filtered.");

  sync_delay_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> ##1 supply_low_s == $past(SUPPLY_LOW_IN, 2))
    else $error("Supply input not synchronised.");
endmodule
`default_nettype wire

/* svr_cpu_model.sv */
// Processor-side model that toggles the watchdog kick line.
`timescale 1ns/1ns
`default_nettype none
module svr_cpu_model #(
  parameter int KICK_PERIOD = 20
) (
  input wire logic clk_in,
  input wire logic kick_en_in,
  output logic kick_out
);
  logic kick_ff = 1'b0;
  int cnt = 0;
  assign kick_out = kick_ff;
  // A stalled program leaves the kick line stuck at its last level, high or low.
  always @(posedge clk_in) begin
    if (kick_en_in) begin
      cnt <= (cnt >= KICK_PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        kick_ff <= ~kick_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* supervisor_reset_watchdog_tb.sv */
// Self-checking bench for the supervisor block.
`timescale 1ns/1ns
`default_nettype none
module supervisor_reset_watchdog_tb;
  localparam int RST = 50;
  localparam int WDG = 400;
  localparam int CSD = 10;
  localparam int AFL = 5;
  localparam int ARS = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sup_low = 1'b0;
  logic sup_warn = 1'b0;
  logic man_n = 1'b1;
  logic kick;
  logic kick_en = 1'b1;
  logic kick_float = 1'b0;
  logic cs_n = 1'b1;
  logic aux = 1'b1;
  logic rst_no, rst_o, fault, cs_no, cs_oe, warn_no, aux_fail;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 60;
  int n;
  logic v;
  logic exp_q[$];

  always #4 clk = ~clk;

  svr_top #(.RST_CYCLES(RST), .WDOG_CYCLES(WDG), .CS_CYCLES(CSD),
    .AUX_FALL_CYCLES(AFL), .AUX_RISE_CYCLES(ARS)) i_svr_top (
    .CLK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_LOW_IN(sup_low), .SUPPLY_WARN_IN(sup_warn),
    .MANUAL_RESET_IN(man_n), .WATCHDOG_KICK_IN(kick), .KICK_FLOAT_IN(kick_float),
    .CHIP_SELECT_N_IN(cs_n), .AUX_MONITOR_IN(aux), .RESET_N_OUT(rst_no), .RESET_OUT(rst_o),
    .WATCHDOG_FAULT_OUT(fault), .CHIP_SELECT_N_OUT(cs_no), .CHIP_SELECT_OE_OUT(cs_oe),
    .SUPPLY_WARN_N_OUT(warn_no), .AUX_FAIL_OUT(aux_fail));

  svr_cpu_model #(.KICK_PERIOD(20)) i_svr_cpu_model (
    .clk_in(clk), .kick_en_in(kick_en), .kick_out(kick));

  task automatic check(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Waits for reset (sel 0) or fault (sel 1) to reach a level; while waiting on reset it checks the reset pair and that chip select stays high.
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while ((sel ? fault : rst_no) !== lvl && cnt < lim) begin
      if (sel == 0) begin
        check(rst_o, ~rst_no);
        check(cs_no, 1'b1);
      end
      step(1);
      cnt++;
    end
  endtask

  task tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    wait_sig(0, 1'b1, RST + 40, n);
    check(n >= RST && n < RST + 40, 1'b1);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      v = $random(seed);
      cs_n <= v;
      exp_q.push_back(v);
      step(4);
      check(cs_no, exp_q.pop_front());
      check(cs_oe, 1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) sup_warn <= i[0];
      step(4);
      check(warn_no, ~i[0]);
    end
    @(posedge clk) aux <= 1'b0;
    step(2);
    check(aux_fail, 1'b1);
    step(AFL + 4);
    check(aux_fail, 1'b0);
    @(posedge clk) aux <= 1'b1;
    step(ARS - 1);
    check(aux_fail, 1'b0);
    step(6);
    check(aux_fail, 1'b1);
    @(posedge clk) kick_en <= 1'b0;
    wait_sig(1, 1'b0, WDG + 20, n);
    check(n > WDG - 26 && n < WDG + 8, 1'b1);
    for (int i = 0; i < 30; i++) begin
      step(1);
      check(fault, 1'b0);
    end
    @(posedge clk) kick_float <= 1'b1;
    step(5);
    check(fault, 1'b1);
    @(posedge clk) kick_float <= 1'b0;
    wait_sig(1, 1'b0, WDG + 20, n);
    check(n > WDG - 8 && n < WDG + 8, 1'b1);
    @(posedge clk) kick_en <= 1'b1;
    step(26);
    check(fault, 1'b1);
    @(posedge clk) cs_n <= 1'b0;
    sup_low <= 1'b1;
    step(5);
    check(rst_no, 1'b0);
    check(rst_o, 1'b1);
    check(cs_no, 1'b0);
    step(CSD + 2);
    check(cs_no, 1'b1);
    check(fault, 1'b1);
    @(posedge clk) sup_low <= 1'b0;
    step(20);
    @(posedge clk) sup_low <= 1'b1;
    step(3);
    @(posedge clk) sup_low <= 1'b0;
    step(1);
    wait_sig(0, 1'b1, RST + 40, n);
    check(n >= RST && n < RST + 10, 1'b1);
    step(5);
    check(cs_no, 1'b0);
    @(posedge clk) man_n <= 1'b0;
    step(5);
    check(rst_no, 1'b0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) man_n <= i[0];
      step(3);
    end
    @(posedge clk) man_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      step(20);
      check(rst_no, 1'b0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
